/* File: src/lvds_output_mode_select.sv */
// lvds output mode select: straps, pixel pairing and lane layout
// assumes a wishbone classic master on clk and a pixel source on
// its own clock, sampled here through two flip-flops
//
// Function
// - in dual output the odd pixel of a pair fills lanes 0-3 and the even one lanes 4-7.
// - the first active pixel after pixel_valid rises always counts as an odd pixel.
// - dual output sends one frame per pixel pair, both lvds clocks at half pixel rate.
// - single output sends one 7-bit lane frame per pixel on lanes 0-3 with clock a only.
// - replicate behaves as single output and copies lanes 0-3 onto lanes 4-7.
// - the output strap level sets bit order from its top bit; codes 00 and 01 are dual.
// - output codes 10 and 11 select single and replicate for either bit order.
// - swapped dual puts odd pixels on lanes 4-7 and even pixels on lanes 0-3.
// - software may replace the strap swap choice through the override register.
// - each clock a frame, and each clock b frame in dual, is two bits high, three low, two high.
`timescale 1ns/1ns
`default_nettype none
module lvds_output_mode_select
  import lvds_mode_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire wb_req_t     wb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire pix_in_t     pix_i,
  output logic             pix_ready,
  input  wire logic [2:0]  output_config_strap,
  input  wire logic [2:0]  link_config_strap,
  output var lvds_frame_t  lvds_o,
  output logic             lvds_valid,
  input  wire logic        lvds_ready,
  output logic             map_sel,
  output logic             repeater_mode,
  output logic             bc_rate_20m,
  output logic             cable_coax
);

  ////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0]                pclk_sy;
    logic                      pclk_d;
    logic [1:0]                de_sy;
    logic [1:0][PIX_BITS-1:0]  rgb_sy;
    logic                      de_prev;
    logic [1:0][2:0]           ocs_sy;
    logic [1:0][2:0]           lcs_sy;
    logic [1:0]                cap_cnt;
    logic                      cap_done;
    logic [2:0]                out_lvl;
    logic [2:0]                lnk_lvl;
    logic                      ovr_en;
    logic                      ovr_swap;
    logic                      ovf;
    logic                      ack;
    logic [31:0]               rdat;
    logic                      half;
    logic [PIX_BITS-1:0]       odd_rgb;
    logic                      push;
    pix_word_t                 push_w;
    logic                      fv;
    lvds_frame_t               frame;
  } st_t;

  st_t                   st_r;
  st_t                   st_nxt;

  logic                  f_valid;
  logic                  f_ready;
  pix_word_t             f_word;
  logic [PIX_BITS-1:0]   f_rgb;
  logic                  f_in_ready;
  logic [$clog2(DEPTH):0] f_level;

  layout_t               layout;
  logic                  dual;
  logic                  swap_eff;
  logic                  pop;
  logic                  pair_go;
  logic                  wb_req;
  logic [27:0]           odd_pk;
  logic [27:0]           new_pk;

  ////////////////////////////////////////////////////////////////
  // lane packing

  // top bit of the strap chooses msb-first or lsb-first layout;
  // the finer per-colour map is left to the panel wiring
  function automatic logic [27:0] pack_pix(
    input logic [PIX_BITS-1:0] rgb,
    input logic                msb
  );
    logic [27:0] w;
    if (msb) begin
      w = {1'b1, 3'h0, rgb};
    end else begin
      w = {1'b1, 3'h0, rgb[1:0], rgb[9:8], rgb[17:16],
           rgb[7:2], rgb[15:10], rgb[23:18]};
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////
  // pixel buffer

  pix_fifo #(
    .W     ($bits(pix_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (st_r.push),
    .in_ready  (f_in_ready),
    .in_data   (st_r.push_w),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_word),
    .level     (f_level)
  );

  ////////////////////////////////////////////////////////////////
  // decode of captured straps

  assign layout   = layout_t'(st_r.out_lvl[1:0]);
  assign dual     = !st_r.out_lvl[1];
  // override replaces the strap swap in every layout; only dual layouts use swap_eff
  assign swap_eff = st_r.ovr_en ? st_r.ovr_swap
                  : (layout == LAY_SWAP);

  assign f_rgb    = f_word.rgb;
  assign f_ready  = st_r.cap_done && (!st_r.fv || lvds_ready);
  assign pop      = f_valid && f_ready;
  assign pair_go  = pop && dual && st_r.half && !f_word.first;
  assign wb_req   = wb_i.cyc && wb_i.stb && !st_r.ack;
  assign odd_pk   = pack_pix(st_r.odd_rgb, st_r.out_lvl[MAP_BIT]);
  assign new_pk   = pack_pix(f_rgb, st_r.out_lvl[MAP_BIT]);

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic fall;
    fall = 1'b0;
    st_nxt = st_r;

    // synchronisers; first stages feed only the second
    st_nxt.pclk_sy = {st_r.pclk_sy[0], pix_i.pclk};
    st_nxt.de_sy   = {st_r.de_sy[0], pix_i.valid};
    st_nxt.rgb_sy  = {st_r.rgb_sy[0], pix_i.rgb};
    st_nxt.ocs_sy  = {st_r.ocs_sy[0], output_config_strap};
    st_nxt.lcs_sy  = {st_r.lcs_sy[0], link_config_strap};
    st_nxt.pclk_d  = st_r.pclk_sy[1];

    // sample half a pixel period after the launching edge
    fall = st_r.pclk_d && !st_r.pclk_sy[1];
    st_nxt.push = 1'b0;
    if (fall) begin
      st_nxt.de_prev = st_r.de_sy[1];
      st_nxt.push = st_r.de_sy[1];
      st_nxt.push_w.first = st_r.de_sy[1] && !st_r.de_prev;
      st_nxt.push_w.rgb = st_r.rgb_sy[1];
    end

    // a sample the full fifo cannot take is lost and flagged
    if (st_r.push && !f_in_ready) begin
      st_nxt.ovf = 1'b1;
    end

    // straps taken once, after the synchronisers have filled
    if (!st_r.cap_done) begin
      if (st_r.cap_cnt == STRAP_SETTLE) begin
        st_nxt.cap_done = 1'b1;
        st_nxt.out_lvl = st_r.ocs_sy[1];
        st_nxt.lnk_lvl = st_r.lcs_sy[1];
      end else begin
        st_nxt.cap_cnt = st_r.cap_cnt + 1'b1;
      end
    end

    // output frame slot
    if (st_r.fv && lvds_ready) begin
      st_nxt.fv = 1'b0;
    end
    if (pop) begin
      if (dual) begin
        if (f_word.first || !st_r.half) begin
          st_nxt.half = 1'b1;
          st_nxt.odd_rgb = f_rgb;
        end else begin
          st_nxt.half = 1'b0;
          st_nxt.fv = 1'b1;
          if (swap_eff) begin
            st_nxt.frame.lane[3:0] = new_pk;
            st_nxt.frame.lane[7:4] = odd_pk;
          end else begin
            st_nxt.frame.lane[3:0] = odd_pk;
            st_nxt.frame.lane[7:4] = new_pk;
          end
          st_nxt.frame.clk_a = LVDS_CLK_PAT;
          st_nxt.frame.clk_b = LVDS_CLK_PAT;
        end
      end else begin
        st_nxt.half = 1'b0;
        st_nxt.fv = 1'b1;
        st_nxt.frame.lane[3:0] = new_pk;
        if (layout == LAY_REPL) begin
          st_nxt.frame.lane[7:4] = new_pk;
        end else begin
          st_nxt.frame.lane[7:4] = '0;
        end
        st_nxt.frame.clk_a = LVDS_CLK_PAT;
        st_nxt.frame.clk_b = '0;
      end
    end

    // wishbone slave, answer one cycle after the request
    st_nxt.ack = wb_req;
    if (wb_req) begin
      st_nxt.rdat = 32'h0000_0000;
      case (wb_i.adr)
        REG_OVR: begin
          st_nxt.rdat[OVR_EN_BIT] = st_r.ovr_en;
          st_nxt.rdat[OVR_SWAP_BIT] = st_r.ovr_swap;
          if (wb_i.we && wb_i.sel[0]) begin
            st_nxt.ovr_en = wb_i.dat[OVR_EN_BIT];
            st_nxt.ovr_swap = wb_i.dat[OVR_SWAP_BIT];
          end
        end
        REG_STATUS: begin
          st_nxt.rdat[ST_OUT_LSB +: 3] = st_r.out_lvl;
          st_nxt.rdat[ST_LNK_LSB +: 3] = st_r.lnk_lvl;
          st_nxt.rdat[ST_SWAP_BIT] = swap_eff;
          st_nxt.rdat[ST_HALF_BIT] = st_r.half;
          st_nxt.rdat[ST_OVF_BIT] = st_r.ovf;
          st_nxt.rdat[ST_CAP_BIT] = st_r.cap_done;
          st_nxt.rdat[ST_LVL_LSB +: $bits(f_level)] = f_level;
        end
        REG_FLAGS: begin
          st_nxt.rdat[FLAG_OVF_BIT] = st_r.ovf;
          // clear loses against a drop in the same cycle
          if (wb_i.we && wb_i.sel[0] && wb_i.dat[FLAG_OVF_BIT]
              && !(st_r.push && !f_in_ready)) begin
            st_nxt.ovf = 1'b0;
          end
        end
        default: begin
          st_nxt.rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.ovr_en <= OVR_EN_RST;
      st_r.ovr_swap <= OVR_SWAP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_o      = st_r.rdat;
  assign wb_ack_o      = st_r.ack;
  assign pix_ready     = f_in_ready;
  assign lvds_o        = st_r.frame;
  assign lvds_valid    = st_r.fv;
  assign map_sel       = st_r.out_lvl[MAP_BIT];
  assign repeater_mode = st_r.lnk_lvl[REP_BIT];
  assign bc_rate_20m   = st_r.lnk_lvl[BC_BIT];
  assign cable_coax    = st_r.lnk_lvl[COAX_BIT];

  ////////////////////////////////////////////////////////////////
  // checks

  a_dual_odd_low: assert property (@(posedge clk) disable iff (!rst_b)
    (pair_go && !swap_eff) |=> lvds_o.lane[3:0] == $past(odd_pk)
      && lvds_o.lane[7:4] == $past(new_pk))
    else $error("odd pixel not on low lanes");

  a_first_is_odd: assert property (@(posedge clk) disable iff (!rst_b)
    (pop && dual && f_word.first) |=> st_r.half
      && st_r.odd_rgb == $past(f_rgb) && !$rose(lvds_valid))
    else $error("first pixel not held as odd");

  a_dual_clocks: assert property (@(posedge clk) disable iff (!rst_b)
    pair_go |=> lvds_valid && lvds_o.clk_a == LVDS_CLK_PAT
      && lvds_o.clk_b == LVDS_CLK_PAT)
    else $error("dual frame clocks wrong");

  a_single_lanes: assert property (@(posedge clk) disable iff (!rst_b)
    (pop && layout == LAY_SINGLE) |=> lvds_valid
      && lvds_o.lane[7:4] == '0 && lvds_o.clk_b == '0
      && lvds_o.lane[3:0] == $past(new_pk))
    else $error("single frame layout wrong");

  a_repl_copy: assert property (@(posedge clk) disable iff (!rst_b)
    (pop && layout == LAY_REPL) |=> lvds_valid
      && lvds_o.lane[7:4] == lvds_o.lane[3:0])
    else $error("replicate lanes differ");

  a_strap_out: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(st_r.cap_done) |-> st_r.out_lvl == $past(st_r.ocs_sy[1])
      && map_sel == (st_r.out_lvl >= 3'h4))
    else $error("output strap decode wrong");

  a_strap_link: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(st_r.cap_done) |-> {repeater_mode, bc_rate_20m, cable_coax}
      == $past(st_r.lcs_sy[1]))
    else $error("link strap decode wrong");

  a_swap_high: assert property (@(posedge clk) disable iff (!rst_b)
    (pair_go && swap_eff) |=> lvds_o.lane[7:4] == $past(odd_pk)
      && lvds_o.lane[3:0] == $past(new_pk))
    else $error("swap did not exchange lanes");

  a_override_wr: assert property (@(posedge clk) disable iff (!rst_b)
    (wb_req && wb_i.we && wb_i.adr == REG_OVR && wb_i.sel[0]) |=>
      st_r.ovr_en == $past(wb_i.dat[OVR_EN_BIT])
      && st_r.ovr_swap == $past(wb_i.dat[OVR_SWAP_BIT]) ##1 wb_ack_o == 1'b0)
    else $error("override write not taken");

  a_clk_pattern: assert property (@(posedge clk) disable iff (!rst_b)
    lvds_valid |-> lvds_o.clk_a == LVDS_CLK_PAT
      && lvds_o.clk_b == (dual ? LVDS_CLK_PAT : 7'h00))
    else $error("lvds clock frame pattern wrong");

  a_strap_hold: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.cap_done |=> $stable(st_r.out_lvl) && $stable(st_r.lnk_lvl))
    else $error("strap levels changed after capture");

endmodule // lvds_output_mode_select
`default_nettype wire

/* File: src/lvds_mode_pkg.sv */
// constants and types for the lvds output mode select block
// assumes a 50 MHz system clock and a sampled pixel port
package lvds_mode_pkg;

  localparam int CLK_MHZ    = 50;
  localparam int PIX_BITS   = 24;
  localparam int LANE_BITS  = 7;
  localparam int FIFO_DEPTH = 32;

  // 7-bit frame clock: two high, three low, two high
  localparam logic [6:0] LVDS_CLK_PAT = 7'h63;

  // strap settle count after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // register byte offsets
  localparam logic [3:0] REG_OVR    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FLAGS  = 4'h8;

  // override register fields and reset values
  localparam int OVR_EN_BIT   = 0;
  localparam int OVR_SWAP_BIT = 1;
  localparam logic OVR_EN_RST   = 1'h0;
  localparam logic OVR_SWAP_RST = 1'h0;

  // flags register
  localparam int FLAG_OVF_BIT = 0;

  // status register fields
  localparam int ST_OUT_LSB  = 0;
  localparam int ST_LNK_LSB  = 3;
  localparam int ST_SWAP_BIT = 6;
  localparam int ST_HALF_BIT = 7;
  localparam int ST_OVF_BIT  = 8;
  localparam int ST_CAP_BIT  = 9;
  localparam int ST_LVL_LSB  = 16;

  // strap level fields
  localparam int MAP_BIT  = 2;
  localparam int REP_BIT  = 2;
  localparam int BC_BIT   = 1;
  localparam int COAX_BIT = 0;

  typedef enum logic [1:0] {
    LAY_DUAL   = 2'b00,
    LAY_SWAP   = 2'b01,
    LAY_SINGLE = 2'b10,
    LAY_REPL   = 2'b11
  } layout_t;

  typedef struct packed {
    logic                pclk;
    logic                valid;
    logic [PIX_BITS-1:0] rgb;
  } pix_in_t;

  typedef struct packed {
    logic                first;
    logic [PIX_BITS-1:0] rgb;
  } pix_word_t;

  typedef struct packed {
    logic [7:0][LANE_BITS-1:0] lane;
    logic [LANE_BITS-1:0]      clk_a;
    logic [LANE_BITS-1:0]      clk_b;
  } lvds_frame_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

/* File: src/pix_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes depth is a power of two; one clock domain
`timescale 1ns/1ns
`default_nettype none
module pix_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 32
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(DEPTH):0]      level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_st_t;

  fifo_st_t st_r;
  fifo_st_t st_nxt;
  logic     push;
  logic     pop;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign level     = st_r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_fifo_count: assert property (@(posedge clk) disable iff (!rst_b)
    (push && !pop) |=> st_r.cnt == $past(st_r.cnt) + 1'b1)
    else $error("fifo count missed a push");
endmodule // pix_fifo
`default_nettype wire

/* File: verif/lvds_panel_model.sv */
// behavioural lvds panel: takes frames on valid and ready, can stall or go slow
// assumes the frame port of the mode select block on the same clock
`timescale 1ns/1ns
`default_nettype none
module lvds_panel_model
  import lvds_mode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire lvds_frame_t frame,
  input  wire logic        valid,
  input  wire logic        stall,
  input  wire logic        slow,
  output logic             ready
);
  lvds_frame_t rx_q[$];
  logic        toggle_r;

  ////////////////////////////////////////////////////////////////////////////
  // slow mode takes a frame only every other cycle, so the sender must hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_r <= 1'b0;
    end else begin
      toggle_r <= ~toggle_r;
    end
  end

  assign ready = !stall && (!slow || toggle_r);

  always @(posedge clk) begin
    if (rst_b && valid && ready) begin
      rx_q.push_back(frame);
    end
  end
endmodule // lvds_panel_model
`default_nettype wire

/* File: verif/testbench.sv */
// testbench for the lvds output mode select block
// assumes the panel model on the frame port and wishbone classic on clk
`timescale 1ns/1ns
`default_nettype none
module testbench
  import lvds_mode_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  wb_req_t     wb_i = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  pix_in_t     pix_i = '0;
  logic        pix_ready;
  logic [2:0]  output_config_strap = 3'h0;
  logic [2:0]  link_config_strap = 3'h0;
  lvds_frame_t lvds_o;
  logic        lvds_valid;
  logic        lvds_ready;
  logic        map_sel;
  logic        repeater_mode;
  logic        bc_rate_20m;
  logic        cable_coax;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  int          failures = 0;
  int          checks = 0;
  logic [31:0] rd;
  logic [23:0] pix_tab [5] = '{24'ha1_b2c3, 24'h5e_6f70, 24'h13_2435, 24'hfe_0d1c, 24'h46_9ab7};
  // two bit periods high, three low, two high
  localparam logic [6:0] CLK_FRAME = 7'h63;

  always #10 clk = ~clk;

  lvds_output_mode_select u_lvds_output_mode_select (.clk, .rst_b, .wb_i, .wb_dat_o, .wb_ack_o,
    .pix_i, .pix_ready, .output_config_strap, .link_config_strap, .lvds_o, .lvds_valid,
    .lvds_ready, .map_sel, .repeater_mode, .bc_rate_20m, .cable_coax);

  lvds_panel_model u_lvds_panel_model (.clk, .rst_b, .frame(lvds_o), .valid(lvds_valid),
    .stall, .slow, .ready(lvds_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [27:0] pack(input logic [23:0] p, input logic msb);
    return msb ? {4'h8, p} : {4'h8, p[1:0], p[9:8], p[17:16], p[7:2], p[15:10], p[23:18]};
  endfunction

  function automatic lvds_frame_t exp_frame(input logic [1:0] lay, input logic msb,
                                            input logic [23:0] p0, input logic [23:0] p1);
    logic [27:0] w0;
    logic [27:0] w1;
    lvds_frame_t f;
    w0 = pack(p0, msb);
    w1 = pack(p1, msb);
    for (int i = 0; i < 4; i++) begin
      f.lane[i]   = (lay == 2'b01) ? w1[7*i +: 7] : w0[7*i +: 7];
      f.lane[i+4] = (lay == 2'b00) ? w1[7*i +: 7] : (lay == 2'b10) ? 7'h00 : w0[7*i +: 7];
    end
    f.clk_a = CLK_FRAME;
    f.clk_b = lay[1] ? 7'h00 : CLK_FRAME;
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                         output logic [31:0] q);
    int n;
    n = 0;
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: dat};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      finish_test();
    end
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge clk);
  endtask

  // straps stay put from reset until well after capture
  task automatic do_reset(input logic [2:0] o, input logic [2:0] l);
    rst_b <= 1'b0;
    output_config_strap <= o;
    link_config_strap <= l;
    stall <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    u_lvds_panel_model.rx_q.delete();
  endtask

  // pixel clock only runs while pixels are sent, 160 ns a pixel
  task automatic send_pix(input logic v, input logic [23:0] rgb);
    pix_i <= '{pclk: 1'b1, valid: v, rgb: rgb};
    repeat (4) @(posedge clk);
    pix_i.pclk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (u_lvds_panel_model.rx_q.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    // a stuck frame path counts as a mismatch
    if (u_lvds_panel_model.rx_q.size() < n) begin
      failures++;
      finish_test();
    end
    repeat (16) @(posedge clk);
  endtask

  // a lone odd pixel (third one) must vanish in dual layouts
  task automatic run_mode(input logic [1:0] lay, input logic msb);
    send_pix(1'b0, 24'h00_0000);
    for (int i = 0; i < 3; i++) send_pix(1'b1, pix_tab[i]);
    send_pix(1'b0, 24'h00_0000);
    send_pix(1'b1, pix_tab[3]);
    send_pix(1'b1, pix_tab[4]);
    send_pix(1'b0, 24'h00_0000);
    wait_frames(lay[1] ? 5 : 2);
    if (!lay[1]) begin
      check("frame count", u_lvds_panel_model.rx_q.size(), 2);
      check("pair 0", u_lvds_panel_model.rx_q[0], exp_frame(lay, msb, pix_tab[0], pix_tab[1]));
      check("pair 1", u_lvds_panel_model.rx_q[1], exp_frame(lay, msb, pix_tab[3], pix_tab[4]));
    end else begin
      check("frame count", u_lvds_panel_model.rx_q.size(), 5);
      for (int i = 0; i < 5; i++) begin
        check("single", u_lvds_panel_model.rx_q[i], exp_frame(lay, msb, pix_tab[i], 0));
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int lv = 0; lv < 8; lv++) begin
      do_reset(lv[2:0], lv[2:0]);
      slow <= lv[0];
      check("map_sel", map_sel, lv[2]);
      check("repeater_mode", repeater_mode, lv[2]);
      check("bc_rate_20m", bc_rate_20m, lv[1]);
      check("cable_coax", cable_coax, lv[0]);
      run_mode(lv[1:0], lv[2]);
      $display("test strap level %0d done", lv);
    end
    slow <= 1'b0;
    do_reset(3'h0, 3'h0);
    wb_xfer(1'b1, REG_OVR, 32'h0000_0003, rd);
    wb_xfer(1'b1, 4'hc, 32'h0000_0000, rd);
    wb_xfer(1'b0, 4'hc, 32'h0000_0000, rd);
    check("unmapped read", rd, 32'h0000_0000);
    wb_xfer(1'b0, REG_OVR, 32'h0000_0000, rd);
    check("override reg", rd, 32'h0000_0003);
    wb_xfer(1'b0, REG_STATUS, 32'h0000_0000, rd);
    check("effective swap", rd[ST_SWAP_BIT], 1'b1);
    run_mode(2'b01, 1'b0);
    do_reset(3'h1, 3'h0);
    wb_xfer(1'b1, REG_OVR, 32'h0000_0001, rd);
    run_mode(2'b00, 1'b0);
    do_reset(3'h1, 3'h0);
    wb_xfer(1'b0, REG_OVR, 32'h0000_0000, rd);
    check("override after reset", rd, 32'h0000_0000);
    run_mode(2'b01, 1'b0);
    $display("test override done");
    do_reset(3'h2, 3'h0);
    stall <= 1'b1;
    for (int i = 0; i < 36; i++) send_pix(1'b1, 24'(i));
    check("pix_ready when full", pix_ready, 1'b0);
    wb_xfer(1'b0, REG_FLAGS, 32'h0000_0000, rd);
    check("overflow flag", rd[FLAG_OVF_BIT], 1'b1);
    stall <= 1'b0;
    wait_frames(32);
    for (int i = 0; i < 32; i++) begin
      check("drained", u_lvds_panel_model.rx_q[i], exp_frame(2'b10, 1'b0, 24'(i), 0));
    end
    wb_xfer(1'b1, REG_FLAGS, 32'h0000_0001, rd);
    wb_xfer(1'b0, REG_FLAGS, 32'h0000_0000, rd);
    check("overflow cleared", rd[FLAG_OVF_BIT], 1'b0);
    $display("test fifo stall done");
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
